// file: rtl/comp_pixel_map.vh
/*
 register offsets, field positions, reset values and pipeline constants for the component input pixel control.
 assumes the includer wants plain `define names only.
*/
`ifndef COMP_PIXEL_MAP_VH
`define COMP_PIXEL_MAP_VH
`define OFS_ANALOG_CTRL5 8'h23
`define OFS_CHAN3_GAIN 8'h24
`define OFS_CHAN4_GAIN 8'h25
`define OFS_DELAY_SWITCH 8'h29
`define OFS_BRIGHTNESS 8'h2a
`define OFS_CONTRAST 8'h2b
`define OFS_SATURATION 8'h2c
`define BIT_CHAN3_TOP 0
`define BIT_CHAN4_TOP 1
`define BIT_SWITCH_ENABLE 7
`define BIT_SWITCH_POLARITY 6
`define SWDL_HI 5
`define SWDL_LO 4
`define BIT_PEAKING 3
`define CPDL_HI 2
`define CPDL_LO 0
`define RST_CTRL5 8'h00
`define RST_GAIN_LOW 8'h90
`define RST_DELAY_SWITCH 8'h00
`define RST_BRIGHTNESS 8'h80
`define RST_GAIN_UNITY 8'h40
`define BRIGHT_NOMINAL 10'h080
`define GAIN_SHIFT 6
`define DELAY_DEPTH 32
`define DELAY_CENTER 5'h10
// composite tap: one past the centre, matching the component peaking register
`define REF_TAP 5'h11
`define CPDL_STEP 5'h04
`define SW_CENTER 5'h02
`define PIX_MAX 8'hff
`define CHROMA_ZERO 8'h80
`endif

// file: rtl/pixel_delay_line.v
/*
 variable pixel delay line built from a shift register array.
 assumes one pixel per enabled clock and a tap index below the depth.
*/
`timescale 1ns/1ps
`include "comp_pixel_map.vh"
module pixel_delay_line #(
	parameter WIDTH = 8
)(
	input wire clk_sys,
	input wire rst,
	input wire pix_en,
	input wire [WIDTH-1:0] din,
	input wire [4:0] tap,
	output wire [WIDTH-1:0] dout
);
	reg [WIDTH-1:0] stage [0:`DELAY_DEPTH-1];
	genvar g;
	generate
		for (g = 0; g < `DELAY_DEPTH; g = g + 1)
		begin : gen_stage
			if (g == 0)
			begin : gen_first
				always @(posedge clk_sys)
				begin
					if (rst)
						stage[g] <= {WIDTH{1'b0}};
					else if (pix_en)
						stage[g] <= din;
				end
			end
			else
			begin : gen_next
				always @(posedge clk_sys)
				begin
					if (rst)
						stage[g] <= {WIDTH{1'b0}};
					else if (pix_en)
						stage[g] <= stage[g-1];
				end
			end
		end
	endgenerate
	assign dout = stage[tap];
endmodule

// file: rtl/component_input_pixel_control.v
/*
 component input pixel control: gain code registers for channels 3 and 4, pixelwise fast switch between decoded
 composite and component picture, delay alignment, luma peaking, brightness, contrast and saturation.
 assumes the two-wire bus slave outside decodes subaddresses into wr_en/rd_addr strobes on clk_sys, pixel inputs
 are synchronous to clk_sys, and the switch pin is asynchronous.
*/
// Notes on behaviour
// - channel 3 gain is nine bits, split registers
// - channel 4 gain likewise, top bit separate
// - enable bit turns on per-pixel switching
// - polarity bit inverts switch input meaning
// - switch disabled: polarity bit is static select
// - switch input delay 0, +1, -2, -1 pixels
// - optional component luma peaking when enabled
// - component delay in four-pixel steps
// - brightness is unsigned offset, 128 nominal
// - contrast is signed gain, 64 is unity
// - saturation is signed gain like contrast
`timescale 1ns/1ps
`include "comp_pixel_map.vh"
module component_input_pixel_control (
	input wire clk_sys,
	input wire rst,
	input wire wr_en,
	input wire [7:0] wr_addr,
	input wire [7:0] wr_data,
	input wire [7:0] rd_addr,
	output reg [7:0] rd_data,
	input wire pix_en,
	input wire [7:0] cvbs_y,
	input wire [7:0] cvbs_c,
	input wire [7:0] comp_y,
	input wire [7:0] comp_c,
	input wire pixel_switch_input,
	output reg [7:0] out_y,
	output reg [7:0] out_c,
	output reg out_is_component,
	output wire [8:0] chan3_gain_code,
	output wire [8:0] chan4_gain_code
);
	reg [7:0] analog_ctrl5;
	reg [7:0] chan3_gain_reg;
	reg [7:0] chan4_gain_reg;
	reg [7:0] component_delay_switch_ctrl;
	reg [7:0] component_brightness_bits;
	reg [7:0] component_contrast_bits;
	reg [7:0] component_saturation_bits;
	reg sw_meta;
	reg sw_sync;
	wire pixel_switch_enable = component_delay_switch_ctrl[`BIT_SWITCH_ENABLE];
	wire pixel_switch_polarity = component_delay_switch_ctrl[`BIT_SWITCH_POLARITY];
	wire [1:0] switch_input_delay = component_delay_switch_ctrl[`SWDL_HI:`SWDL_LO];
	wire component_luma_peaking = component_delay_switch_ctrl[`BIT_PEAKING];
	wire [2:0] component_path_delay = component_delay_switch_ctrl[`CPDL_HI:`CPDL_LO];

	// signed pixel offset of a three-bit step code, in four-pixel units; positive codes delay the component
	function [4:0] comp_tap;
		input [2:0] code;
		begin
			comp_tap = `DELAY_CENTER + {code[2], code[2], code[2:0]} * `CPDL_STEP;
		end
	endfunction

	// signed gain multiply around a centre, then clip to the byte range
	function [7:0] gain_clip;
		input [9:0] centred;
		input [7:0] gain;
		input [9:0] offset;
		reg signed [19:0] prod;
		reg signed [19:0] sum;
		begin
			prod = ($signed(centred) * $signed(gain)) >>> `GAIN_SHIFT;
			sum = prod + $signed({10'h000, offset});
			if (sum < 0)
				gain_clip = 8'h00;
			else if (sum > $signed({12'h000, `PIX_MAX}))
				gain_clip = `PIX_MAX;
			else
				gain_clip = sum[7:0];
		end
	endfunction

	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			analog_ctrl5 <= `RST_CTRL5;
			chan3_gain_reg <= `RST_GAIN_LOW;
			chan4_gain_reg <= `RST_GAIN_LOW;
			component_delay_switch_ctrl <= `RST_DELAY_SWITCH;
			component_brightness_bits <= `RST_BRIGHTNESS;
			component_contrast_bits <= `RST_GAIN_UNITY;
			component_saturation_bits <= `RST_GAIN_UNITY;
		end
		else if (wr_en)
		begin
			case (wr_addr)
				`OFS_ANALOG_CTRL5: analog_ctrl5 <= wr_data;
				`OFS_CHAN3_GAIN: chan3_gain_reg <= wr_data;
				`OFS_CHAN4_GAIN: chan4_gain_reg <= wr_data;
				`OFS_DELAY_SWITCH: component_delay_switch_ctrl <= wr_data;
				`OFS_BRIGHTNESS: component_brightness_bits <= wr_data;
				`OFS_CONTRAST: component_contrast_bits <= wr_data;
				`OFS_SATURATION: component_saturation_bits <= wr_data;
				default: ;
			endcase
		end
	end

	always @(posedge clk_sys)
	begin
		if (rst)
			rd_data <= 8'h00;
		else
		begin
			case (rd_addr)
				`OFS_ANALOG_CTRL5: rd_data <= analog_ctrl5;
				`OFS_CHAN3_GAIN: rd_data <= chan3_gain_reg;
				`OFS_CHAN4_GAIN: rd_data <= chan4_gain_reg;
				`OFS_DELAY_SWITCH: rd_data <= component_delay_switch_ctrl;
				`OFS_BRIGHTNESS: rd_data <= component_brightness_bits;
				`OFS_CONTRAST: rd_data <= component_contrast_bits;
				`OFS_SATURATION: rd_data <= component_saturation_bits;
				default: rd_data <= 8'h00;
			endcase
		end
	end

	assign chan3_gain_code = {analog_ctrl5[`BIT_CHAN3_TOP], chan3_gain_reg};
	assign chan4_gain_code = {analog_ctrl5[`BIT_CHAN4_TOP], chan4_gain_reg};

	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			sw_meta <= 1'b0;
			sw_sync <= 1'b0;
		end
		else
		begin
			sw_meta <= pixel_switch_input;
			sw_sync <= sw_meta;
		end
	end

	// composite reference sits one past the centre to cover the peaking stage; component moves around the centre
	wire [7:0] ref_y;
	wire [7:0] ref_c;
	wire [7:0] dl_y;
	wire [7:0] dl_c;
	wire sw_bit;
	wire [4:0] c_tap = comp_tap(component_path_delay);
	reg [4:0] sw_tap;
	always @*
	begin
		case (switch_input_delay)
			2'b01: sw_tap = `SW_CENTER + 5'd1;
			2'b10: sw_tap = `SW_CENTER - 5'd2;
			2'b11: sw_tap = `SW_CENTER - 5'd1;
			default: sw_tap = `SW_CENTER;
		endcase
	end
	// switch tap follows the component tap; clamped so an early shift cannot wrap to the far end
	wire [5:0] sw_sum = {1'b0, c_tap} + {1'b0, sw_tap};
	wire [4:0] sw_tap_eff = (sw_sum < {1'b0, `SW_CENTER}) ? 5'h00 : sw_sum[4:0] - `SW_CENTER;

	pixel_delay_line #(.WIDTH(8)) u_ref_y (.clk_sys(clk_sys), .rst(rst), .pix_en(pix_en), .din(cvbs_y),
		.tap(`REF_TAP), .dout(ref_y));
	pixel_delay_line #(.WIDTH(8)) u_ref_c (.clk_sys(clk_sys), .rst(rst), .pix_en(pix_en), .din(cvbs_c),
		.tap(`REF_TAP), .dout(ref_c));
	pixel_delay_line #(.WIDTH(8)) u_comp_y (.clk_sys(clk_sys), .rst(rst), .pix_en(pix_en), .din(comp_y),
		.tap(c_tap), .dout(dl_y));
	pixel_delay_line #(.WIDTH(8)) u_comp_c (.clk_sys(clk_sys), .rst(rst), .pix_en(pix_en), .din(comp_c),
		.tap(c_tap), .dout(dl_c));
	pixel_delay_line #(.WIDTH(1)) u_sw (.clk_sys(clk_sys), .rst(rst), .pix_en(pix_en), .din(sw_sync),
		.tap(sw_tap_eff), .dout(sw_bit));

	// three-tap peaking kernel: y + (2y - prev - next)/8 gives roughly +2 dB mid band
	reg [7:0] py_prev;
	reg [7:0] py_cur;
	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			py_prev <= 8'h00;
			py_cur <= 8'h00;
		end
		else if (pix_en)
		begin
			py_prev <= py_cur;
			py_cur <= dl_y;
		end
	end
	wire signed [11:0] hp = $signed({3'h0, py_cur, 1'b0}) - $signed({4'h0, py_prev}) - $signed({4'h0, dl_y});
	wire signed [11:0] peaked = $signed({4'h0, py_cur}) + (hp >>> 3);
	wire [7:0] peaked_clip = peaked < 0 ? 8'h00 : (peaked > $signed({4'h0, `PIX_MAX}) ? `PIX_MAX : peaked[7:0]);
	wire [7:0] luma_in = component_luma_peaking ? peaked_clip : py_cur;

	// luma: (y - 128) * contrast / 64 + brightness; chroma: (c - 128) * saturation / 64 + 128
	wire [9:0] y_centred = {2'b00, luma_in} - `BRIGHT_NOMINAL;
	wire [9:0] c_centred = {2'b00, dl_c} - {2'b00, `CHROMA_ZERO};
	wire [7:0] proc_y = gain_clip(y_centred, component_contrast_bits,
		{2'b00, component_brightness_bits});
	wire [7:0] proc_c = gain_clip(c_centred, component_saturation_bits, {2'b00, `CHROMA_ZERO});

	reg pick_comp;
	always @*
	begin
		if (pixel_switch_enable)
			pick_comp = sw_bit ^ pixel_switch_polarity;
		else
			pick_comp = pixel_switch_polarity;
	end

	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			out_y <= 8'h00;
			out_c <= `CHROMA_ZERO;
			out_is_component <= 1'b0;
		end
		else if (pix_en)
		begin
			out_is_component <= pick_comp;
			out_y <= pick_comp ? proc_y : ref_y;
			out_c <= pick_comp ? proc_c : ref_c;
		end
	end
endmodule

// file: tb/comp_pixel_assertions.sv
/* port checker for the component pixel control.
 assumes clk_sys with synchronous active high rst. */
`timescale 1ns/1ps
module comp_pixel_assertions (
	input wire clk_sys,
	input wire rst,
	input wire wr_en,
	input wire [7:0] wr_addr,
	input wire [7:0] wr_data,
	input wire [7:0] rd_addr,
	input wire [7:0] rd_data,
	input wire pix_en,
	input wire [7:0] out_y,
	input wire [7:0] out_c,
	input wire out_is_component,
	input wire [8:0] chan3_gain_code,
	input wire [8:0] chan4_gain_code
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	chk_ch3_low: assert property (wr_en && wr_addr == 8'h24 |=> chan3_gain_code[7:0] == $past(wr_data))
		else $error("ch3 low byte not taken");
	chk_ch4_low: assert property (wr_en && wr_addr == 8'h25 |=> chan4_gain_code[7:0] == $past(wr_data))
		else $error("ch4 low byte not taken");
	chk_ch3_top: assert property (wr_en && wr_addr == 8'h23 |=> chan3_gain_code[8] == $past(wr_data[0]))
		else $error("ch3 top bit not taken");
	chk_ch4_top: assert property (wr_en && wr_addr == 8'h23 |=> chan4_gain_code[8] == $past(wr_data[1]))
		else $error("ch4 top bit not taken");
	chk_reset_out: assert property (disable iff (1'b0) rst |=> out_y == 8'h00 && out_c == 8'h80
		&& !out_is_component && chan3_gain_code == 9'h090 && chan4_gain_code == 9'h090)
		else $error("reset values wrong");
	chk_unmapped_read: assert property (!(rd_addr inside {8'h23, 8'h24, 8'h25, 8'h29, 8'h2a, 8'h2b, 8'h2c})
		|=> rd_data == 8'h00) else $error("unmapped read not zero");
	chk_ch3_read: assert property (rd_addr == 8'h24 |=> rd_data == $past(chan3_gain_code[7:0]))
		else $error("ch3 read back wrong");
	chk_output_hold: assert property (!pix_en |=> $stable(out_y) && $stable(out_c) && $stable(out_is_component))
		else $error("output moved without pixel enable");
endmodule
bind component_input_pixel_control comp_pixel_assertions comp_pixel_assertions_i (.clk_sys, .rst, .wr_en,
	.wr_addr, .wr_data, .rd_addr, .rd_data, .pix_en, .out_y, .out_c, .out_is_component, .chan3_gain_code,
	.chan4_gain_code);

// file: tb/pixel_source.sv
/* pixel source model: pixel valid cadence and switch pin.
 assumes clk_sys from the bench. */
`timescale 1ns/1ps
module pixel_source (
	input wire clk_sys,
	input wire sw_level,
	output reg pix_en,
	output reg pixel_switch_input
);
	reg [1:0] phase = 2'h0;
	initial pix_en = 1'b0;
	initial pixel_switch_input = 1'b0;
	always @(posedge clk_sys)
	begin
		phase <= phase + 2'h1;
		pix_en <= #2 phase != 2'h3;
		pixel_switch_input <= #2 sw_level;
	end
endmodule

// file: tb/tb.sv
/* self-checking bench for the component pixel control.
 assumes the bound checker and the pixel source model. */
`timescale 1ns/1ps
module tb;
	reg clk_sys = 0;
	reg rst = 1;
	reg wr_en = 0;
	reg sw_level = 0;
	reg [7:0] wr_addr = 0, wr_data = 0, rd_addr = 0, cvbs_y = 0, cvbs_c = 0, comp_y = 0, comp_c = 0;
	reg [31:0] seed = 32'h9bf8;
	integer miscompares = 0, total_checks = 0, i;
	integer base, sbase, ny, ns;
	reg [7:0] top;
	wire pix_en, pixel_switch_input, out_is_component;
	wire [7:0] rd_data, out_y, out_c;
	wire [8:0] chan3_gain_code, chan4_gain_code;
	always #12.5 clk_sys = ~clk_sys;
	component_input_pixel_control component_input_pixel_control_i (.clk_sys, .rst, .wr_en, .wr_addr, .wr_data,
		.rd_addr, .rd_data, .pix_en, .cvbs_y, .cvbs_c, .comp_y, .comp_c, .pixel_switch_input, .out_y, .out_c,
		.out_is_component, .chan3_gain_code, .chan4_gain_code);
	pixel_source pixel_source_i (.clk_sys, .sw_level, .pix_en, .pixel_switch_input);
	function [31:0] lfsr(input [31:0] x);
		lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function [7:0] clip(input integer v);
		clip = v < 0 ? 8'h00 : v > 255 ? 8'hff : v[7:0];
	endfunction
	// component shift in pixels for a delay code; positive is later
	function integer cpdl_shift(input [2:0] code);
		cpdl_shift = code[2] ? 4 * code - 32 : 4 * code;
	endfunction
	function integer sw_shift(input [1:0] code);
		sw_shift = code == 2'b01 ? 1 : code == 2'b10 ? -2 : code == 2'b11 ? -1 : 0;
	endfunction
	task check(input [15:0] seen, input [15:0] want);
		begin
			total_checks = total_checks + 1;
			if (seen !== want)
			begin
				miscompares = miscompares + 1;
				$display("wrong value at %0t: saw %h expected %h", $time, seen, want);
			end
		end
	endtask
	task tally_and_finish;
		begin
			$display("checks %0d mismatches %0d", total_checks, miscompares);
			if (miscompares == 0 && total_checks > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge clk_sys) #2;
			wr_en = 1;
			wr_addr = a;
			wr_data = d;
			@(posedge clk_sys) #2;
			wr_en = 0;
		end
	endtask
	task rd(input [7:0] a, input [7:0] want);
		begin
			@(posedge clk_sys) #2;
			rd_addr = a;
			@(posedge clk_sys) #2;
			check(rd_data, want);
		end
	endtask
	task px(input [7:0] ctrl, input [7:0] con, input [7:0] sat, input [7:0] bri, input integer y, input integer c,
		input sel);
		begin
			wr(8'h29, ctrl);
			wr(8'h2b, con);
			wr(8'h2c, sat);
			wr(8'h2a, bri);
			comp_y = y[7:0];
			comp_c = c[7:0];
			cvbs_y = ~comp_y;
			cvbs_c = ~comp_c;
			repeat (64) @(posedge clk_sys);
			#2;
			check(out_is_component, sel);
			check(out_y, sel ? clip((((y - 128) * $signed(con)) >>> 6) + $signed({1'b0, bri})) : cvbs_y);
			check(out_c, sel ? clip((((c - 128) * $signed(sat)) >>> 6) + 128) : cvbs_c);
		end
	endtask
	// step luma and switch pin at a fixed pixel phase; count pixel edges until each shows at the output
	task step(input [7:0] ctrl, output integer lat_y, output integer lat_s, output [7:0] peak);
		integer n;
		begin
			comp_y = 8'h10;
			cvbs_y = 8'h10;
			sw_level = 0;
			wr(8'h29, ctrl);
			repeat (64) @(posedge clk_sys);
			@(negedge pix_en);
			comp_y = 8'hc0;
			cvbs_y = 8'hc0;
			sw_level = 1;
			n = 0;
			lat_y = -1;
			lat_s = -1;
			peak = 8'h00;
			repeat (64)
			begin
				@(posedge clk_sys);
				if (pix_en)
					n = n + 1;
				#2;
				if (lat_y < 0 && out_y == 8'hc0)
					lat_y = n;
				if (lat_s < 0 && out_is_component)
					lat_s = n;
				if (out_y > peak)
					peak = out_y;
			end
			sw_level = 0;
		end
	endtask
	initial
	begin
		repeat (8) @(posedge clk_sys);
		#2 rst = 0;
		rd(8'h24, 8'h90);
		rd(8'h25, 8'h90);
		rd(8'h2a, 8'h80);
		rd(8'h2b, 8'h40);
		rd(8'h2c, 8'h40);
		rd(8'h29, 8'h00);
		wr(8'h23, 8'h03);
		wr(8'h24, 8'hff);
		check(chan3_gain_code, 9'h1ff);
		for (i = 0; i < 8; i = i + 1)
		begin
			seed = lfsr(seed);
			wr(8'h24, seed[7:0]);
			wr(8'h25, seed[15:8]);
			wr(8'h23, {6'h00, seed[17:16]});
			check(chan3_gain_code, {seed[16], seed[7:0]});
			check(chan4_gain_code, {seed[17], seed[15:8]});
			rd(8'h25, seed[15:8]);
		end
		wr(8'h26, 8'h55);
		rd(8'h26, 8'h00);
		px(8'h00, 8'h40, 8'h40, 8'h80, 200, 150, 0);
		px(8'h40, 8'h40, 8'h40, 8'h80, 200, 150, 1);
		px(8'h48, 8'h7f, 8'h00, 8'h80, 255, 200, 1);
		px(8'h44, 8'h80, 8'h80, 8'h80, 255, 192, 1);
		for (i = 0; i < 4; i = i + 1)
		begin
			seed = lfsr(seed);
			px({2'b01, seed[5:4], 1'b0, seed[2:0]}, seed[31:24], 8'h7f, seed[15:8], seed[23:16], 255, 1);
		end
		sw_level = 1;
		px(8'h80, 8'h40, 8'h40, 8'h80, 100, 100, 1);
		px(8'hc0, 8'h40, 8'h40, 8'h80, 100, 100, 0);
		sw_level = 0;
		px(8'h90, 8'h40, 8'h40, 8'h80, 100, 100, 0);
		px(8'hf0, 8'h40, 8'h40, 8'h80, 100, 100, 1);
		step(8'h00, base, ns, top);
		check(top, 8'hc0);
		for (i = 0; i < 8; i = i + 1)
		begin
			step({5'b01000, i[2:0]}, ny, ns, top);
			check(ny - base, cpdl_shift(i[2:0]));
			check(top, 8'hc0);
		end
		step(8'h48, ny, ns, top);
		check(top > 8'hc0, 1);
		step(8'h80, ny, sbase, top);
		for (i = 1; i < 4; i = i + 1)
		begin
			step({2'b10, i[1:0], 4'h0}, ny, ns, top);
			check(ns - sbase, sw_shift(i[1:0]));
		end
		tally_and_finish;
	end
	initial
	begin
		#200000;
		miscompares = miscompares + 1;
		tally_and_finish;
	end
endmodule
